//--- verification/bxpt_properties.sv
// Purpose: Port checker for block translation logic.
// Assumes: One clock, synchronous active-low reset.
// Notes: Lookup outputs follow inputs by one cycle.
`timescale 1ns/1ps
module bxpt_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic wide_mode,
  input wire logic [63:0] logical_addr,
  input wire logic [10:0] area_size_mask,
  input wire logic [46:0] area_logical_page_tag,
  input wire logic [46:0] area_physical_page_number,
  input wire logic block_hit,
  input wire logic [27:0] block_offset,
  input wire logic [63:0] block_physical_addr,
  input wire logic [27:0] block_length_bytes_div
);
  logic p_ok, p_w;
  logic [63:0] p_la;
  logic [10:0] p_m;
  logic [46:0] p_tag, p_ppn;
  always_ff @(posedge clk) begin
    p_ok <= reset_n;
    p_w <= wide_mode;
    p_la <= logical_addr;
    p_m <= area_size_mask;
    p_tag <= area_logical_page_tag;
    p_ppn <= area_physical_page_number;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered");
  wait_short_a: assert property ($fell(avs_waitrequest) |-> ##1 avs_waitrequest)
    else $error("waitrequest low too long");
  unmapped_a: assert property (avs_read && avs_waitrequest && avs_address == 5'h10 |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  length_a: assert property (p_ok |-> block_length_bytes_div == 28'h1 << $countones(p_m))
    else $error("block length wrong");
  offset_a: assert property (p_ok |-> block_offset == {p_la[27:17] & p_m, p_la[16:0]})
    else $error("block offset wrong");
  hit_wide_a: assert property (p_ok && p_w |-> block_hit == ((p_la[63:17] & ~{36'h0, p_m}) == p_tag))
    else $error("wide hit wrong");
  hit_narrow_a: assert property (p_ok && !p_w |-> block_hit == ((p_la[31:17] & ~{4'h0, p_m}) == p_tag[14:0]))
    else $error("narrow hit wrong");
  phys_addr_a: assert property (p_ok && p_w |->
    block_physical_addr == {p_ppn | (p_la[63:17] & {36'h0, p_m}), p_la[16:0]})
    else $error("physical address wrong");
  cover property (p_ok && block_hit);
  cover property (avs_write && !avs_waitrequest);
  cover property (avs_read && !avs_waitrequest);
endmodule
bind bxpt_top bxpt_properties i_props (.clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .wide_mode, .logical_addr, .area_size_mask, .area_logical_page_tag,
  .area_physical_page_number, .block_hit, .block_offset, .block_physical_addr, .block_length_bytes_div);

//--- verification/bxpt_top_bench.sv
// Purpose: Self-checking bench for block translation logic.
// Assumes: 125 MHz clock, reset held 16 cycles.
// Notes: Register reset reads first, then lookup rows, then register cases.
`timescale 1ns/1ps
module bxpt_top_bench import bxpt_pkg::*;;
  typedef struct packed {logic w; logic [3:0] k; logic [63:0] la; logic [46:0] tag; logic hit;} bxpt_row_s;
  // Physical page number aligned to the largest block.
  localparam logic [46:0] PPN = 47'h7edcba987800;
  localparam logic [45:0] ORG = 46'h0123456789a8;
  localparam logic [38:0] HASH = 39'h5aa5a5a5ff;
  logic clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, req_wide = 1'b1;
  logic [4:0] avs_address = 5'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] req_len = 4'h0;
  logic [63:0] req_la = 64'h0, logical_addr, block_physical_addr, group_addr, table_size_bytes;
  logic [46:0] req_tag = 47'h0, area_logical_page_tag;
  logic [38:0] req_hash = 39'h0, hash_value;
  logic [10:0] area_size_mask;
  logic [27:0] block_offset, block_length_bytes_div;
  logic avs_waitrequest, wide_mode, block_hit;
  int err_total = 0, compares = 0;
  bxpt_row_s rows [6] = '{'{1'b1, 4'h0, {47'h123456789801, 17'h01abc}, 47'h123456789801, 1'b1},
    '{1'b1, 4'hb, {47'h123456789fff, 17'h1ffff}, 47'h123456789800, 1'b1},
    '{1'b1, 4'h4, {47'h12345678980f, 17'h00000}, 47'h123456789810, 1'b0},
    '{1'b1, 4'h3, {47'h123456789a07, 17'h00000}, 47'h123456789a00, 1'b1},
    '{1'b0, 4'h5, {32'hdeadbeef, 15'h503f, 17'h02345}, 47'h5020, 1'b1},
    '{1'b0, 4'h2, {32'h0, 15'h2800, 17'h00001}, 47'h5000, 1'b0}};
  bxpt_walk_model i_walk (.req_wide, .req_len, .req_la, .req_tag, .req_hash, .wide_mode, .logical_addr,
    .area_size_mask, .area_logical_page_tag, .hash_value);
  bxpt_top i_dut (.clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
    .avs_readdata, .avs_waitrequest, .wide_mode, .logical_addr, .area_size_mask, .area_logical_page_tag,
    .area_physical_page_number(PPN), .hash_value, .block_hit, .block_offset, .block_physical_addr,
    .block_length_bytes_div, .group_addr, .table_size_bytes);
  ////////////////////////////////////////
  initial forever #4 clk = ~clk;
  task automatic final_report;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n == 20) begin
      err_total++;
      final_report();
    end
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("readdata", 64'(e), 64'(q));
  endtask
  task automatic look(input logic w, input logic [3:0] k, input logic [63:0] la, input logic [46:0] t);
    @(posedge clk);
    req_wide <= w;
    req_len <= k;
    req_la <= la;
    req_tag <= t;
    req_hash <= HASH;
    @(posedge clk);
    @(negedge clk);
  endtask
  initial begin
    logic [10:0] m;
    logic [63:0] pe;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 12; a += 4) rdchk(5'(a), 32'h0);
    foreach (rows[i]) begin
      look(rows[i].w, rows[i].k, rows[i].la, rows[i].tag);
      m = 11'((12'h1 << rows[i].k) - 12'h1);
      chk("hit", 64'(rows[i].hit), 64'(block_hit));
      chk("offset", 64'({rows[i].la[27:17] & m, rows[i].la[16:0]}), 64'(block_offset));
      pe = rows[i].w ? {PPN | (rows[i].la[63:17] & 47'(m)), rows[i].la[16:0]} :
                       {32'h0, PPN[14:0] | (rows[i].la[31:17] & 15'(m)), rows[i].la[16:0]};
      chk("phys", pe, block_physical_addr);
    end
    for (int k = 0; k < 12; k++) begin
      look(1'b1, 4'(k), 64'h0, 47'h0);
      chk("length", 64'h1 << k, 64'(block_length_bytes_div));
    end
    bus(1'b1, BXPT_OFS_WIDE_LO, 32'hfffffffc);
    rdchk(BXPT_OFS_WIDE_LO, 32'hfffc001c);
    bus(1'b1, BXPT_OFS_NARROW, 32'hffffffff);
    rdchk(BXPT_OFS_NARROW, 32'hffff01ff);
    bus(1'b1, 5'h10, 32'hffffffff);
    rdchk(5'h10, 32'h0);
    bus(1'b1, BXPT_OFS_WIDE_HI, ORG[45:14]);
    bus(1'b1, BXPT_OFS_WIDE_LO, {ORG[13:0], 18'h3});
    look(1'b1, 4'h0, 64'h0, 47'h0);
    chk("group", {ORG, 18'h0} | (64'(HASH[13:11]) << 18) | (64'(HASH[10:0]) << 7), group_addr);
    chk("table", 64'h1 << 21, table_size_bytes);
    bus(1'b1, BXPT_OFS_WIDE_LO, 32'h1f);
    look(1'b1, 4'h0, 64'h0, 47'h0);
    chk("table", 64'h1 << 46, table_size_bytes);
    rdchk(BXPT_OFS_STATUS, 32'h3);
    bus(1'b1, BXPT_OFS_WIDE_LO, 32'h1c);
    bus(1'b1, BXPT_OFS_STATUS, 32'h2);
    rdchk(BXPT_OFS_STATUS, 32'h1);
    bus(1'b1, BXPT_OFS_NARROW, 32'habc80007);
    look(1'b0, 4'h0, 64'h0, 47'h0);
    chk("group", {32'h0, 16'habc8 | 16'(HASH[12:10]), HASH[9:0], 6'h0}, group_addr);
    chk("table", 64'h1 << 19, table_size_bytes);
    // Mid-run reset clears descriptors and lookup outputs.
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("hit_rst", 64'h0, 64'(block_hit));
    chk("group_rst", 64'h0, group_addr);
    @(posedge clk);
    reset_n <= 1'b1;
    rdchk(BXPT_OFS_NARROW, 32'h0);
    rdchk(BXPT_OFS_WIDE_LO, 32'h0);
    final_report();
  end
endmodule

//--- verification/bxpt_walk_model.sv
// Purpose: Address generation side that feeds lookups.
// Assumes: Requests change just after a clock edge.
// Notes: Length is given as a count of mask ones.
`timescale 1ns/1ps
module bxpt_walk_model (
  input wire logic req_wide,
  input wire logic [3:0] req_len,
  input wire logic [63:0] req_la,
  input wire logic [46:0] req_tag,
  input wire logic [38:0] req_hash,
  output logic wide_mode,
  output logic [63:0] logical_addr,
  output logic [10:0] area_size_mask,
  output logic [46:0] area_logical_page_tag,
  output logic [38:0] hash_value
);
  assign wide_mode = req_wide;
  assign logical_addr = req_la;
  // Tag aligned to the block size.
  assign area_logical_page_tag = req_tag & ~{36'h0, area_size_mask};
  assign hash_value = req_hash;
  assign area_size_mask = 11'((12'h1 << req_len) - 12'h1);
endmodule

//--- verilog/bxpt_block_match.sv
// Purpose: One block-area match and address offset/physical address former.
// Assumes: Inputs come from logic in the same clock domain.
// Notes: Combinational; mask LSB sits at logical bit LA_W-18 (big-endian).
`timescale 1ns/1ps
module bxpt_block_match
  import bxpt_pkg::*;
#(
  parameter int LA_W = 64
) (
  input wire logic [LA_W-1:0] logical_addr,
  input wire logic [BXPT_MASK_W-1:0] area_size_mask,
  input wire logic [LA_W-BXPT_BLK_LOW_W-1:0] area_logical_page_tag,
  input wire logic [LA_W-BXPT_BLK_LOW_W-1:0] area_physical_page_number,
  output logic hit,
  output logic [BXPT_MASK_W+BXPT_BLK_LOW_W-1:0] block_offset,
  output logic [LA_W-1:0] physical_addr
);
  localparam int HI_W = LA_W - BXPT_BLK_LOW_W;
  localparam int TAG_W = HI_W - BXPT_MASK_W;
  wire logic [HI_W-1:0] la_hi = logical_addr[LA_W-1 -: HI_W];
  // RULE3 mask alignment: mask LSB is the bit just above the 17 low bits.
  wire logic [HI_W-1:0] wide_mask = {{TAG_W{1'b0}}, area_size_mask};
  // RULE4 masked compare.
  wire logic [HI_W-1:0] la_cleared = la_hi & ~wide_mask;
  assign hit = (la_cleared == area_logical_page_tag);
  // RULE5 block offset.
  assign block_offset = {la_hi[BXPT_MASK_W-1:0] & area_size_mask, logical_addr[BXPT_BLK_LOW_W-1:0]};
  // RULE18 RULE19 physical address.
  assign physical_addr = {area_physical_page_number | (la_hi & wide_mask), logical_addr[BXPT_BLK_LOW_W-1:0]};
endmodule

//--- verilog/bxpt_pkg.sv
// Purpose: Shared constants for block translation and page table base logic.
// Assumes: Big-endian bit numbering maps to little-endian vectors (bit k is index width-1-k).
// Notes: Register offsets are Avalon-MM byte addresses.
package bxpt_pkg;
  localparam int BXPT_MASK_W = 11;
  localparam int BXPT_BLK_LOW_W = 17;
  localparam int BXPT_LA_W = 64;
  localparam int BXPT_LA32_W = 32;
  // 64-bit descriptor: origin bits 0-45, size code bits 59-63.
  localparam int BXPT_W_ORG_W = 46;
  localparam int BXPT_W_ORG_LSB = 18;
  localparam int BXPT_W_SIZE_LSB = 0;
  localparam int BXPT_W_SIZE_W = 5;
  localparam int BXPT_W_BASE_HASH = 11;
  localparam int BXPT_W_GRP_SHIFT = 7;
  localparam logic [4:0] BXPT_W_SIZE_MAX = 5'h1c;
  // 32-bit descriptor: origin bits 0-15, index mask bits 23-31.
  localparam int BXPT_N_ORG_W = 16;
  localparam int BXPT_N_ORG_LSB = 16;
  localparam int BXPT_N_MASK_W = 9;
  localparam int BXPT_N_BASE_HASH = 10;
  localparam int BXPT_N_GRP_SHIFT = 6;
  // Register byte offsets.
  localparam logic [4:0] BXPT_OFS_WIDE_LO = 5'h00;
  localparam logic [4:0] BXPT_OFS_WIDE_HI = 5'h04;
  localparam logic [4:0] BXPT_OFS_NARROW = 5'h08;
  localparam logic [4:0] BXPT_OFS_STATUS = 5'h0c;
  localparam logic [63:0] BXPT_WIDE_RESET = 64'h0;
  localparam logic [31:0] BXPT_NARROW_RESET = 32'h0;
  localparam logic [31:0] BXPT_UNMAPPED = 32'h0;
  typedef enum logic [1:0] {
    BXPT_IDLE = 2'b00,
    BXPT_DONE = 2'b01
  } bxpt_bus_e;
endpackage

//--- verilog/bxpt_top.sv
// Purpose: Block-area translation and page table descriptor registers.
// Assumes: Avalon-MM slave with waitrequest; one clock, synchronous reset.
// Notes: Lookups are registered one cycle after the request inputs.
//
// Functional notes
// RULE1 - Area size mask: zeros give 128 Kbytes, each low one doubles, to 256 Mbytes.
// RULE2 - Software loads only right-justified runs of ones into the area size mask.
// RULE3 - Mask LSB aligns with logical bit 46 (wide) or bit 14 (narrow).
// RULE4 - Clear logical bits under mask ones, compare with tag; equality is a hit.
// RULE5 - Block offset is masked logical bits joined to 17 lower bits.
// RULE6 - Software aligns tag and physical page number to the block size.
// RULE7 - Wide descriptor: origin 0-45, reserved 46-58, size code 59-63.
// RULE8 - Wide origin gives high 46 physical address bits, 256 Kbyte aligned.
// RULE9 - Wide form: at least 11 hash bits index 128-byte entry groups.
// RULE10 - Size code n makes mask of n ones; n above 28 is clamped.
// RULE11 - Software zeroes origin low bits matching extra hash bits.
// RULE12 - Software keeps size code at 25 or below for 64-bit virtual addresses.
// RULE13 - Narrow descriptor: origin 0-15, reserved 16-22, index mask 23-31.
// RULE14 - Narrow origin gives high 16 physical address bits, 64 Kbyte aligned.
// RULE15 - Narrow form: at least 10 hash bits index 64-byte entry groups.
// RULE16 - Software loads the narrow index mask as zeros then ones.
// RULE17 - Software zeroes narrow origin low bits matching mask ones.
// RULE18 - Physical page number with mask forms high physical block address bits.
// RULE19 - Physical block address ORs masked logical bits into physical page number.
// RULE20 - Group address ORs masked hash into origin, appends hash and offset.
`timescale 1ns/1ps
module bxpt_top
  import bxpt_pkg::*;
#(
  parameter int HASH_W = 39
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic wide_mode,
  input wire logic [BXPT_LA_W-1:0] logical_addr,
  input wire logic [BXPT_MASK_W-1:0] area_size_mask,
  input wire logic [BXPT_LA_W-BXPT_BLK_LOW_W-1:0] area_logical_page_tag,
  input wire logic [BXPT_LA_W-BXPT_BLK_LOW_W-1:0] area_physical_page_number,
  input wire logic [HASH_W-1:0] hash_value,
  output logic block_hit,
  output logic [BXPT_MASK_W+BXPT_BLK_LOW_W-1:0] block_offset,
  output logic [BXPT_LA_W-1:0] block_physical_addr,
  output logic [27:0] block_length_bytes_div,
  output logic [BXPT_LA_W-1:0] group_addr,
  output logic [BXPT_LA_W-1:0] table_size_bytes
);
  ////////////////////////////////////////////////////////////////////////////
  logic [63:0] page_table_descriptor_wide;
  logic [31:0] page_table_descriptor_narrow;
  bxpt_bus_e bus_state;
  bxpt_bus_e next_bus_state;
  logic clamp_seen;

  wire logic access = avs_read | avs_write;
  wire logic take = access & (bus_state == BXPT_IDLE);
  // Writes land at the edge where the master sees waitrequest low.
  wire logic commit = (bus_state == BXPT_DONE);
  wire logic sel_wlo = avs_address == BXPT_OFS_WIDE_LO;
  wire logic sel_whi = avs_address == BXPT_OFS_WIDE_HI;
  wire logic sel_nar = avs_address == BXPT_OFS_NARROW;
  wire logic sel_sts = avs_address == BXPT_OFS_STATUS;
  wire logic [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // RULE7 wide field split.
  wire logic [BXPT_W_ORG_W-1:0] w_origin = page_table_descriptor_wide[63 -: BXPT_W_ORG_W];
  wire logic [BXPT_W_SIZE_W-1:0] w_size = page_table_descriptor_wide[BXPT_W_SIZE_LSB +: BXPT_W_SIZE_W];
  // RULE13 narrow field split.
  wire logic [BXPT_N_ORG_W-1:0] n_origin = page_table_descriptor_narrow[31 -: BXPT_N_ORG_W];
  wire logic [BXPT_N_MASK_W-1:0] n_mask = page_table_descriptor_narrow[BXPT_N_MASK_W-1:0];

  // RULE10 clamp size code and build mask.
  wire logic [4:0] w_size_eff = (w_size > BXPT_W_SIZE_MAX) ? BXPT_W_SIZE_MAX : w_size;
  wire logic [27:0] w_mask_gen;
  genvar gi;
  generate
    for (gi = 0; gi < 28; gi++) begin : g_wm
      assign w_mask_gen[gi] = (5'(gi) < w_size_eff);
    end
  endgenerate

  // RULE9 RULE20 wide group address.
  wire logic [BXPT_W_BASE_HASH-1:0] w_hash_lo = hash_value[BXPT_W_BASE_HASH-1:0];
  wire logic [27:0] w_hash_hi = hash_value[BXPT_W_BASE_HASH +: 28];
  wire logic [BXPT_W_ORG_W-1:0] w_org_mix = w_origin | {18'h0, w_hash_hi & w_mask_gen};
  // RULE8 origin is the high 46 bits.
  wire logic [63:0] w_group = {w_org_mix, w_hash_lo, 7'h00};

  // RULE15 RULE20 narrow group address.
  wire logic [BXPT_N_BASE_HASH-1:0] n_hash_lo = hash_value[BXPT_N_BASE_HASH-1:0];
  wire logic [BXPT_N_MASK_W-1:0] n_hash_hi = hash_value[BXPT_N_BASE_HASH +: BXPT_N_MASK_W];
  wire logic [BXPT_N_ORG_W-1:0] n_org_mix = n_origin | {7'h00, n_hash_hi & n_mask};
  // RULE14 origin is the high 16 bits.
  wire logic [31:0] n_group = {n_org_mix, n_hash_lo, 6'h00};

  // Table size in bytes for each form.
  wire logic [63:0] w_tsize = 64'h40000 << w_size_eff;
  wire logic [63:0] n_tsize = {32'h0, 32'h10000 << $countones(n_mask)};

  // RULE1 length decode: block length in 128 Kbyte units.
  wire logic [27:0] len_units = 28'({17'h0, area_size_mask} + 28'h1);

  ////////////////////////////////////////////////////////////////////////////
  wire logic [63:0] la_narrow = {32'h0, logical_addr[BXPT_LA32_W-1:0]};
  wire logic [63:0] la_sel = wide_mode ? logical_addr : la_narrow;
  wire logic hit_w;
  wire logic [BXPT_MASK_W+BXPT_BLK_LOW_W-1:0] off_w;
  wire logic [63:0] pa_w;
  wire logic hit_n;
  wire logic [BXPT_MASK_W+BXPT_BLK_LOW_W-1:0] off_n;
  wire logic [31:0] pa_n;

  bxpt_block_match #(.LA_W(BXPT_LA_W)) u_match_w (
    .logical_addr(la_sel),
    .area_size_mask(area_size_mask),
    .area_logical_page_tag(area_logical_page_tag),
    .area_physical_page_number(area_physical_page_number),
    .hit(hit_w),
    .block_offset(off_w),
    .physical_addr(pa_w)
  );

  bxpt_block_match #(.LA_W(BXPT_LA32_W)) u_match_n (
    .logical_addr(logical_addr[BXPT_LA32_W-1:0]),
    .area_size_mask(area_size_mask),
    .area_logical_page_tag(area_logical_page_tag[BXPT_LA32_W-BXPT_BLK_LOW_W-1:0]),
    .area_physical_page_number(area_physical_page_number[BXPT_LA32_W-BXPT_BLK_LOW_W-1:0]),
    .hit(hit_n),
    .block_offset(off_n),
    .physical_addr(pa_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  wire logic [31:0] status_word = {30'h0, clamp_seen, wide_mode};
  wire logic [31:0] rd_mux = sel_wlo ? page_table_descriptor_wide[31:0] :
                             sel_whi ? page_table_descriptor_wide[63:32] :
                             sel_nar ? page_table_descriptor_narrow :
                             sel_sts ? status_word : BXPT_UNMAPPED;
  wire logic [31:0] next_wlo = (page_table_descriptor_wide[31:0] & ~be_mask) | (avs_writedata & be_mask);
  wire logic [31:0] next_whi = (page_table_descriptor_wide[63:32] & ~be_mask) | (avs_writedata & be_mask);
  wire logic [31:0] next_nar = (page_table_descriptor_narrow & ~be_mask) | (avs_writedata & be_mask);
  // Reserved fields are held at zero on write.
  wire logic [63:0] wide_keep = {{BXPT_W_ORG_W{1'b1}}, 13'h0, 5'h1f};
  wire logic [31:0] narrow_keep = {16'hffff, 7'h00, 9'h1ff};
  assign next_bus_state = take ? BXPT_DONE : BXPT_IDLE;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_state <= BXPT_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      bus_state <= next_bus_state;
      avs_waitrequest <= ~take;
      avs_readdata <= (take & avs_read) ? rd_mux : avs_readdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      page_table_descriptor_wide <= BXPT_WIDE_RESET;
      page_table_descriptor_narrow <= BXPT_NARROW_RESET;
      clamp_seen <= 1'b0;
    end else begin
      if (commit & avs_write & sel_wlo) begin
        page_table_descriptor_wide[31:0] <= next_wlo & wide_keep[31:0];
      end
      if (commit & avs_write & sel_whi) begin
        page_table_descriptor_wide[63:32] <= next_whi & wide_keep[63:32];
      end
      if (commit & avs_write & sel_nar) begin
        page_table_descriptor_narrow <= next_nar & narrow_keep;
      end
      // RULE10 flag oversized code, set wins over clear.
      if (w_size > BXPT_W_SIZE_MAX) begin
        clamp_seen <= 1'b1;
      end else if (commit & avs_write & sel_sts & avs_byteenable[0] & avs_writedata[1]) begin
        clamp_seen <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      block_hit <= 1'b0;
      block_offset <= '0;
      block_physical_addr <= '0;
      block_length_bytes_div <= '0;
      group_addr <= '0;
      table_size_bytes <= '0;
    end else begin
      block_hit <= wide_mode ? hit_w : hit_n;
      block_offset <= wide_mode ? off_w : off_n;
      block_physical_addr <= wide_mode ? pa_w : {32'h0, pa_n};
      block_length_bytes_div <= len_units;
      group_addr <= wide_mode ? w_group : {32'h0, n_group};
      table_size_bytes <= wide_mode ? w_tsize : n_tsize;
    end
  end
endmodule
